// ==== rtl/nor_async_access.sv ====
// Asynchronous NOR read/write access sequencer with programmable strobe timing
`timescale 1ns/1ps
module nor_async_access #(
  parameter int ADDR_W = nor_async_pkg::ADDR_W, // Address width
  parameter int DATA_W = nor_async_pkg::DATA_W, // Data width
  parameter int CNT_W = nor_async_pkg::CNT_W // Timing field width
) (
  input wire logic ref_clk_i, // 200 MHz functional clock
  input wire logic sys_rst_i, // Synchronous reset, active high
  input wire logic req_i, // Access request, taken when idle
  input wire logic req_write_i, // 1 write, 0 read
  input wire logic [1:0] req_cs_i, // Chip select index
  input wire logic [ADDR_W-1:0] req_addr_i, // Word address
  input wire logic [1:0] req_be_n_i, // Byte enables, active low
  input wire logic [nor_async_pkg::PAGE_W-1:0] req_page_words_i, // Extra page words
  input wire logic [DATA_W-1:0] req_wdata_i, // Write data
  input wire logic [1:0] timing_scale_sel_i, // Scale minus one
  input wire logic [1:0] ext_clk_divider_i, // External clock divider
  input wire logic [CNT_W-1:0] cs_assert_point_i, // Chip select on
  input wire logic [CNT_W-1:0] cs_rd_off_point_i, // Chip select off, read
  input wire logic [CNT_W-1:0] cs_wr_off_point_i, // Chip select off, write
  input wire logic [CNT_W-1:0] latch_assert_point_i, // Latch strobe on
  input wire logic [CNT_W-1:0] latch_release_point_rd_i, // Latch off, read
  input wire logic [CNT_W-1:0] latch_release_point_wr_i, // Latch off, write
  input wire logic [CNT_W-1:0] oe_assert_point_i, // Output enable on
  input wire logic [CNT_W-1:0] oe_release_point_i, // Output enable off
  input wire logic [CNT_W-1:0] we_assert_point_i, // Write strobe on
  input wire logic [CNT_W-1:0] we_release_point_i, // Write strobe off
  input wire logic [CNT_W-1:0] first_sample_count_i, // First data sample
  input wire logic [CNT_W-1:0] page_sample_count_i, // Page data spacing
  input wire logic [CNT_W-1:0] cycle_time_i, // Access length
  input wire logic [CNT_W-1:0] inter_access_gap_i, // Gap between accesses
  input wire logic [nor_async_pkg::NUM_WAIT-1:0] mem_wait_in_i, // Wait lines
  input wire logic [DATA_W-1:0] mem_data_i, // Data bus input
  output logic busy_o, // Access or gap in progress
  output logic ready_o, // Request may be taken
  output logic [nor_async_pkg::NUM_WAIT-1:0] wait_seen_o, // Wait lines, registered
  output logic rdata_valid_o, // One-cycle pulse per sampled word
  output logic [DATA_W-1:0] rdata_o, // Sampled read data
  output logic [nor_async_pkg::NUM_CS-1:0] mem_chip_sel_n_o, // Chip selects
  output logic [ADDR_W-1:0] mem_addr_out_o, // Address
  output logic addr_valid_o, // Address is valid
  output logic low_byte_en_n_o, // Low byte enable
  output logic high_byte_en_n_o, // High byte enable
  output logic addr_latch_strobe_n_o, // Address latch strobe
  output logic out_enable_n_o, // Output enable
  output logic write_strobe_n_o, // Write strobe
  output logic [DATA_W-1:0] mem_data_o, // Data bus output
  output logic mem_data_oe_o, // Data bus driven
  output logic ext_if_clk_o // External interface clock
);
  import nor_async_pkg::*;

  // Multiply a timing field by the scale, which is the select value plus one
  function automatic logic [TCNT_W-1:0] scaled(input logic [CNT_W-1:0] v,
                                               input logic [1:0] sel);
    scaled = TCNT_W'({2'b00, v} * ({1'b0, sel} + 3'h1));
  endfunction

  // ===========================================================
  // Sequencer state
  acc_state_e state_r;
  logic [TCNT_W-1:0] tcnt_r;
  logic [TCNT_W-1:0] gap_cnt_r;
  logic [TCNT_W-1:0] next_sample_r;
  logic [PAGE_W-1:0] pages_left_r;
  logic is_write_r;
  logic [1:0] cs_idx_r;
  logic [1:0] scale_r;
  logic [PAGE_W-1:0] pages_total_r;
  logic [TCNT_W-1:0] end_time;
  logic [TCNT_W-1:0] cs_off_time;
  logic start;
  logic sample_now;
  logic tick;

  assign ready_o = (state_r == ST_IDLE);
  assign start = req_i && ready_o;
  assign busy_o = !ready_o;
  // Page words stretch the cycle and the chip-select window by one page spacing each
  assign end_time = scaled(cycle_time_i, scale_r)
                    + TCNT_W'(pages_total_r) * scaled(page_sample_count_i, scale_r);
  assign cs_off_time = scaled(is_write_r ? cs_wr_off_point_i : cs_rd_off_point_i, scale_r)
                       + TCNT_W'(pages_total_r) * scaled(page_sample_count_i, scale_r);
  assign sample_now = (state_r == ST_ACCESS) && !is_write_r && (tcnt_r == next_sample_r);

  // Request capture; scale is latched so a change mid-access cannot bend the timing
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      is_write_r <= 1'b0;
      cs_idx_r <= 2'h0;
      scale_r <= 2'h0;
      pages_total_r <= '0;
      mem_addr_out_o <= ADDR_RST;
      mem_data_o <= DATA_RST;
    end else if (start) begin
      is_write_r <= req_write_i;
      cs_idx_r <= req_cs_i;
      scale_r <= timing_scale_sel_i;
      pages_total_r <= req_write_i ? '0 : req_page_words_i;
      mem_addr_out_o <= req_addr_i;
      mem_data_o <= req_wdata_i;
    end
  end

  // Access and gap sequencing; the timebase clears at every start
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      state_r <= ST_IDLE;
      tcnt_r <= '0;
      gap_cnt_r <= '0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (start) begin
            state_r <= ST_ACCESS;
            tcnt_r <= '0;
          end
        end
        ST_ACCESS: begin
          if (tcnt_r + 1'b1 >= end_time) begin
            state_r <= ST_GAP;
            gap_cnt_r <= '0;
          end else begin
            tcnt_r <= tcnt_r + 1'b1;
          end
        end
        ST_GAP: begin
          // Address stays invalid for the gap before the next access may start
          if (gap_cnt_r + 1'b1 >= TCNT_W'(inter_access_gap_i)) begin
            state_r <= ST_IDLE;
          end
          gap_cnt_r <= gap_cnt_r + 1'b1;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Sample schedule: first at the access time, then at each page spacing
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      next_sample_r <= '0;
      pages_left_r <= '0;
    end else if (start) begin
      next_sample_r <= scaled(first_sample_count_i, timing_scale_sel_i);
      pages_left_r <= req_write_i ? '0 : req_page_words_i;
    end else if (sample_now && pages_left_r != '0) begin
      next_sample_r <= next_sample_r + scaled(page_sample_count_i, scale_r);
      pages_left_r <= pages_left_r - 1'b1;
    end
  end

  // Read data capture; memory is trusted to be valid by the sample point
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      rdata_o <= DATA_RST;
      rdata_valid_o <= 1'b0;
    end else begin
      rdata_valid_o <= sample_now;
      if (sample_now) begin
        rdata_o <= mem_data_i;
      end
    end
  end

  // ===========================================================
  // Strobe generation against the shared timebase; byte enables come from start, wait lines are only registered
  logic in_acc;
  assign in_acc = (state_r == ST_ACCESS);

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      mem_chip_sel_n_o <= '1;
      addr_latch_strobe_n_o <= 1'b1;
      out_enable_n_o <= 1'b1;
      write_strobe_n_o <= 1'b1;
      low_byte_en_n_o <= 1'b1;
      high_byte_en_n_o <= 1'b1;
      addr_valid_o <= 1'b0;
      mem_data_oe_o <= 1'b0;
      wait_seen_o <= '0;
    end else begin
      wait_seen_o <= mem_wait_in_i;
      for (int i = 0; i < NUM_CS; i++) begin
        mem_chip_sel_n_o[i] <= !(in_acc && cs_idx_r == 2'(i)
          && tcnt_r >= scaled(cs_assert_point_i, scale_r)
          && tcnt_r < cs_off_time);
      end
      addr_latch_strobe_n_o <= !(in_acc && tcnt_r >= scaled(latch_assert_point_i, scale_r)
        && tcnt_r < scaled(is_write_r ? latch_release_point_wr_i
                                      : latch_release_point_rd_i, scale_r));
      out_enable_n_o <= !(in_acc && !is_write_r
        && tcnt_r >= scaled(oe_assert_point_i, scale_r)
        && tcnt_r < scaled(oe_release_point_i, scale_r)
                    + TCNT_W'(pages_total_r) * scaled(page_sample_count_i, scale_r));
      write_strobe_n_o <= !(in_acc && is_write_r
        && tcnt_r >= scaled(we_assert_point_i, scale_r)
        && tcnt_r < scaled(we_release_point_i, scale_r));
      // Byte enables held for the whole access, dropped in the gap; the address holds until the next start
      low_byte_en_n_o <= start ? req_be_n_i[0] : (in_acc ? low_byte_en_n_o : 1'b1);
      high_byte_en_n_o <= start ? req_be_n_i[1] : (in_acc ? high_byte_en_n_o : 1'b1);
      // Address flag rises with the timebase, so its lead on chip select is exactly the delay
      addr_valid_o <= in_acc && !(tcnt_r + 1'b1 >= end_time);
      mem_data_oe_o <= start ? req_write_i : (in_acc && is_write_r && tcnt_r + 1'b1 < end_time);
    end
  end

  // ===========================================================
  // External interface clock from the divider enable
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      ext_if_clk_o <= 1'b0;
    end else if (ext_clk_divider_i == DIV_ZERO) begin
      ext_if_clk_o <= !ext_if_clk_o;
    end else if (tick) begin
      ext_if_clk_o <= !ext_if_clk_o;
    end
  end

  tick_divider u_div (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .restart_i(start),
    .div_sel_i(ext_clk_divider_i),
    .tick_o(tick)
  );

  // ===========================================================
  // Checks
  logic [TCNT_W-1:0] chk_cnt_r;
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || start) begin
      chk_cnt_r <= '0;
    end else if (chk_cnt_r != '1) begin
      chk_cnt_r <= chk_cnt_r + 1'b1;
    end
  end

  AST_FIRST_SAMPLE: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    sample_now && chk_cnt_r == next_sample_r && pages_left_r == pages_total_r
    |-> tcnt_r == scaled(first_sample_count_i, scale_r))
    else $error("first sample not at scaled access time");
  AST_SAMPLE_PULSE: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    sample_now |=> rdata_valid_o && rdata_o == $past(mem_data_i))
    else $error("sample not captured");
  AST_PAGE_STEP: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    sample_now && pages_left_r != '0 |=>
    next_sample_r == $past(next_sample_r) + scaled(page_sample_count_i, scale_r))
    else $error("page spacing wrong");
  AST_RESTART: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    start |=> tcnt_r == '0 && state_r == ST_ACCESS)
    else $error("timebase not restarted");
  AST_ONE_CS: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    $countones(~mem_chip_sel_n_o) <= 1)
    else $error("more than one chip select low");
  AST_CS_ADDR: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    !(|(~mem_chip_sel_n_o)) ##1 (|(~mem_chip_sel_n_o)) |-> addr_valid_o && low_byte_en_n_o
      == $past(low_byte_en_n_o))
    else $error("chip select without valid address");
  AST_OE_READ: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    !out_enable_n_o |-> !is_write_r && $past(in_acc))
    else $error("output enable outside read");
  AST_GAP: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    state_r == ST_GAP |-> !addr_valid_o && mem_chip_sel_n_o == '1)
    else $error("address valid in gap");
endmodule

// ==== rtl/nor_async_pkg.sv ====
// Package: widths, reset values and state codes for the async NOR access sequencer
package nor_async_pkg;
  localparam int ADDR_W = 27;
  localparam int DATA_W = 16;
  localparam int CNT_W = 5;
  localparam int TCNT_W = 12;
  localparam int NUM_CS = 4;
  localparam int NUM_WAIT = 2;
  localparam int PAGE_W = 3;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  localparam logic [1:0] DIV_ZERO = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_RST = 27'h0000000;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACCESS = 2'b01,
    ST_GAP = 2'b10
  } acc_state_e;
endpackage

// ==== rtl/tick_divider.sv ====
// Divider that emits a one-cycle enable at the selected fraction of the functional clock
`timescale 1ns/1ps
module tick_divider (
  input wire logic ref_clk_i, // Functional clock
  input wire logic sys_rst_i, // Synchronous reset, active high
  input wire logic restart_i, // Realign phase at access start
  input wire logic [1:0] div_sel_i, // Divide ratio minus one
  output logic tick_o // One-cycle enable
);
  import nor_async_pkg::*;
  logic [1:0] div_cnt_r;

  // Counts down the ratio; zero divider gives a tick every cycle
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || restart_i || div_cnt_r == DIV_ZERO) begin
      div_cnt_r <= div_sel_i;
    end else begin
      div_cnt_r <= div_cnt_r - 2'h1;
    end
  end

  assign tick_o = (div_cnt_r == DIV_ZERO);
endmodule

// ==== verif/nor_mem_model.sv ====
// Behavioural parallel NOR memory that answers the async access sequencer
`timescale 1ns/1ps
module nor_mem_model (
  input wire logic ref_clk_i, // Functional clock
  input wire logic sel_n_i, // Chip select of this memory
  input wire logic oe_n_i, // Output enable
  input wire logic [26:0] addr_i, // Word address
  input wire logic [31:0] first_i, // Clocks from select low to first word
  input wire logic [31:0] span_i, // Clocks per page word
  output logic [15:0] data_o // Read data bus
);
  logic [31:0] cnt_r;
  logic [15:0] idle_r = 16'hA5C3;
  // Clocks since select; a released bus shows a pattern that flips every cycle
  always_ff @(posedge ref_clk_i) begin
    cnt_r <= sel_n_i ? 32'h0 : cnt_r + 32'h1;
    idle_r <= ~data_o;
  end
  // Each word is valid only around its own sampling point, so early capture fails
  always_comb begin
    if (!sel_n_i && !oe_n_i && cnt_r + 32'h1 >= first_i) begin
      data_o = addr_i[15:0] ^ 16'((cnt_r + 32'h1 - first_i) / span_i);
    end else begin
      data_o = idle_r;
    end
  end
endmodule

// ==== verif/testbench.sv ====
// Self-checking bench for the async NOR access sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_total++; \
  $display("mismatch at %0t got %0h expected %0h", $time, (a), (b)); end end
module testbench;
  import nor_async_pkg::*;
  // ==========================================================================
  // Stimulus, observed outputs and monitor state
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic req_i = 1'b0, wr = 1'b0;
  logic [1:0] cs_sel = 2'h0, be = 2'h0, scale = 2'h0, div = 2'h0, wait_in = 2'h0, wait_q;
  logic [2:0] pages = 3'h0;
  logic [ADDR_W-1:0] addr = 27'h0000000;
  logic [DATA_W-1:0] wdata = 16'h0000;
  logic [CNT_W-1:0] cs_on, cs_rdoff, cs_wroff, la_on, la_rdoff, la_wroff, oe_on, oe_off;
  logic [CNT_W-1:0] we_on, we_off, first, page, cyc_len, gap;
  logic ready, rv, av, lbe, hbe, lat_n, oe_n, we_n, mdoe, busy, ext_clk;
  logic ext_p = 1'b0;
  logic [1:0] div_p = 2'h0;
  logic [1:0] wseen;
  logic [3:0] csn;
  logic [15:0] rdata, mdo, mdi;
  logic [26:0] maddr;
  logic [31:0] s0, span;
  logic av_p = 1'b0, cs_p = 1'b1, la_p = 1'b1, oe_p = 1'b1, we_p = 1'b1, seen = 1'b0;
  int seed = 32'h6F9761BF;
  int err_total = 0, comparisons = 0, cyc = 0, inv = 0, gap_q = 0;
  int t_av, t_csf, t_csr, t_laf, t_lar, t_oef, t_oer, t_wef, t_wer;
  int rv_t[$];
  logic [15:0] rv_d[$];
  // Model timing follows the programmed counts, scaled as the device scales them
  assign s0 = (int'(first) - int'(cs_on)) * (int'(scale) + 1);
  assign span = int'(page) * (int'(scale) + 1);
  nor_async_access dut (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .req_i(req_i), .req_write_i(wr),
    .req_cs_i(cs_sel), .req_addr_i(addr), .req_be_n_i(be), .req_page_words_i(pages),
    .req_wdata_i(wdata), .timing_scale_sel_i(scale), .ext_clk_divider_i(div),
    .cs_assert_point_i(cs_on), .cs_rd_off_point_i(cs_rdoff), .cs_wr_off_point_i(cs_wroff),
    .latch_assert_point_i(la_on), .latch_release_point_rd_i(la_rdoff),
    .latch_release_point_wr_i(la_wroff), .oe_assert_point_i(oe_on),
    .oe_release_point_i(oe_off), .we_assert_point_i(we_on), .we_release_point_i(we_off),
    .first_sample_count_i(first), .page_sample_count_i(page), .cycle_time_i(cyc_len),
    .inter_access_gap_i(gap), .mem_wait_in_i(wait_in), .mem_data_i(mdi), .busy_o(busy),
    .ready_o(ready), .wait_seen_o(wseen), .rdata_valid_o(rv), .rdata_o(rdata),
    .mem_chip_sel_n_o(csn), .mem_addr_out_o(maddr), .addr_valid_o(av),
    .low_byte_en_n_o(lbe), .high_byte_en_n_o(hbe), .addr_latch_strobe_n_o(lat_n),
    .out_enable_n_o(oe_n), .write_strobe_n_o(we_n), .mem_data_o(mdo),
    .mem_data_oe_o(mdoe), .ext_if_clk_o(ext_clk));
  nor_mem_model mem (.ref_clk_i(ref_clk_i), .sel_n_i(csn[cs_sel]), .oe_n_i(oe_n),
    .addr_i(maddr), .first_i(s0), .span_i(span), .data_o(mdi));
  function automatic int rnd(input int n);
    rnd = int'($unsigned($random(seed)) % n);
  endfunction
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // 200 MHz functional clock
  initial begin
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end
  // ==========================================================================
  // Monitor: pre-edge samples, so every recorded time shares one offset
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc > 30000) begin
      err_total++;
      give_verdict();
    end
    wait_in <= {wait_in[0], ~wait_in[1]};
    if (!sys_rst_i) begin
      if (cyc > 15) `CHK(wseen, wait_q)
      wait_q = wait_in;
      `CHK(busy, !ready)
      // The divider value seen last edge is the one the design acted on
      if (cyc > 15 && div_p == 2'h0) `CHK(ext_clk, !ext_p)
      ext_p = ext_clk;
      div_p = div;
      if (av && !av_p) begin
        if (seen) `CHK(inv >= gap_q, 1'b1)
        t_av = cyc;
        t_oef = -1;
        t_wef = -1;
        rv_t.delete();
        rv_d.delete();
      end
      if (!av && av_p) begin
        gap_q = int'(gap);
        seen = 1'b1;
      end
      inv = av ? 0 : inv + 1;
      if (av) begin
        `CHK({hbe, lbe}, be)
        `CHK(csn | (4'h1 << cs_sel), 4'hF)
      end
      if (csn[cs_sel] !== cs_p) if (cs_p) t_csf = cyc; else t_csr = cyc;
      if (lat_n !== la_p) if (la_p) t_laf = cyc; else t_lar = cyc;
      if (oe_n !== oe_p) if (oe_p) t_oef = cyc; else t_oer = cyc;
      if (we_n !== we_p) if (we_p) t_wef = cyc; else t_wer = cyc;
      if (rv) begin
        rv_t.push_back(cyc);
        rv_d.push_back(rdata);
      end
      if (mdoe) `CHK(mdo, wdata)
      av_p = av;
      cs_p = csn[cs_sel];
      la_p = lat_n;
      oe_p = oe_n;
      we_p = we_n;
    end
  end
  // ==========================================================================
  // One access: random legal timing, corner cases for the first two
  task automatic access(input int k);
    int s, co, lo, oo, f, wo, pg, gp, m, pw, i;
    bit w;
    s = (k == 0) ? 0 : (k == 1) ? 3 : rnd(4);
    pg = (k == 0) ? 7 : (k == 1) ? 0 : rnd(4);
    gp = (k == 0) ? 0 : (k == 1) ? 31 : rnd(6);
    w = (k < 2) ? 1'b0 : 1'(rnd(2));
    co = (k == 0) ? 0 : rnd(3);
    lo = co + rnd(2);
    oo = co + rnd(3);
    f = oo + 1 + rnd(3);
    wo = co + rnd(2);
    @(posedge ref_clk_i);
    scale <= 2'(s); pages <= 3'(pg); gap <= 5'(gp); wr <= w; cs_on <= 5'(co);
    la_on <= 5'(lo); la_rdoff <= 5'(lo + 1 + rnd(3)); la_wroff <= 5'(lo + 1 + rnd(3));
    oe_on <= 5'(oo); first <= 5'(f); oe_off <= 5'(f + 1 + rnd(2));
    cs_rdoff <= 5'(f + 2 + rnd(2)); we_on <= 5'(wo); we_off <= 5'(wo + 1 + rnd(3));
    cs_wroff <= 5'(wo + 4 + rnd(2)); cyc_len <= 5'(11 + rnd(2)); page <= 5'(2 + rnd(3));
    cs_sel <= (k == 0) ? 2'h3 : 2'(rnd(4)); be <= 2'(rnd(4)); div <= 2'(rnd(4));
    addr <= 27'($random(seed)); wdata <= 16'($random(seed)); req_i <= 1'b1;
    @(posedge ref_clk_i);
    while (ready !== 1'b1) @(posedge ref_clk_i);
    req_i <= 1'b0;
    @(posedge ref_clk_i);
    while (ready !== 1'b1) @(posedge ref_clk_i);
    m = s + 1;
    pw = w ? 0 : pg * int'(page);
    `CHK(t_csf - t_av, co * m)
    `CHK(t_csr - t_csf, (int'(w ? cs_wroff : cs_rdoff) + pw - co) * m)
    `CHK(t_laf - t_csf, (lo - co) * m)
    `CHK(t_lar - t_csf, (int'(w ? la_wroff : la_rdoff) - co) * m)
    if (w) begin
      `CHK(t_wef - t_csf, (wo - co) * m)
      `CHK(t_wer - t_csf, (int'(we_off) - co) * m)
      `CHK(t_oef, -1)
      `CHK(rv_t.size(), 0)
    end else begin
      `CHK(t_oef - t_csf, (oo - co) * m)
      `CHK(t_oer - t_csf, (int'(oe_off) + pw - co) * m)
      `CHK(t_wef, -1)
      `CHK(rv_t.size(), pg + 1)
      for (i = 0; i < rv_t.size(); i++) begin
        `CHK(rv_t[i] - t_csf, (f - co + i * int'(page)) * m)
        `CHK(rv_d[i], addr[15:0] ^ 16'(i))
      end
    end
  endtask
  // Main sequence: reset, idle check, then a run of accesses
  initial begin
    {cs_on, cs_rdoff, cs_wroff, la_on, la_rdoff, la_wroff, oe_on} = {7{5'h00}};
    {oe_off, we_on, we_off, first, page, cyc_len, gap} = {7{5'h01}};
    repeat (12) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge ref_clk_i);
    `CHK(csn, 4'hF)
    `CHK(ready, 1'b1)
    `CHK(av, 1'b0)
    for (int k = 0; k < 60; k++) begin
      access(k);
      $display("test %0d done", k);
    end
    give_verdict();
  end
endmodule
